// [dv/spc_properties.sv]
`timescale 1ns/1ps
module spc_properties
	import spc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// Power mode, pins and interrupt
	input wire logic stop_mode,
	input wire logic [7:0] shared_port_pins_out,
	input wire logic [7:0] shared_port_pins_oe_n,
	input wire logic irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Counts rising serial clocks while select is driven low.
	logic [3:0] rise_cnt_reg;
	wire logic ss_low = !shared_port_pins_oe_n[PIN_SS] &&
		!shared_port_pins_out[PIN_SS];
	always_ff @(posedge aclk) begin
		if (!aresetn || !ss_low) begin
			rise_cnt_reg <= 4'h0;
		end else if ($rose(shared_port_pins_out[PIN_SCK])) begin
			rise_cnt_reg <= rise_cnt_reg + 4'h1;
		end
	end

	bvalid_hold_a: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	rvalid_hold_a: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	read_answer_a: assert property (
		arvalid && arready |=> rvalid && rdata[31:8] == 24'h000000)
		else $error("read not answered next cycle");
	write_answer_a: assert property (
		awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write not answered in time");
	sck_freeze_a: assert property (
		stop_mode && $past(stop_mode) && $past(stop_mode, 2)
		|-> $stable(shared_port_pins_out[6:5]))
		else $error("serial pins moved in stop");
	stop_keep_a: assert property (
		stop_mode && $past(stop_mode) && $past(stop_mode, 2)
		|-> $stable(shared_port_pins_oe_n)
		&& $stable(shared_port_pins_out[PIN_SS]))
		else $error("pin setup changed in stop");
	reset_idle_a: assert property (disable iff (1'h0)
		!aresetn |=> shared_port_pins_oe_n == 8'hFF && !irq && !bvalid
		&& !rvalid)
		else $error("block not idle after reset");
	eight_clocks_a: assert property (
		$rose(shared_port_pins_out[PIN_SS]) && !shared_port_pins_oe_n[PIN_SS]
		|-> rise_cnt_reg == 4'h8)
		else $error("select released without eight clocks");

	cover property (stop_mode && ss_low);
	cover property ($rose(irq));
	cover property (rvalid && rresp == RESP_SLVERR);
endmodule

bind spc_top spc_properties u_props (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp,
	.bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid,
	.rready, .stop_mode, .shared_port_pins_out, .shared_port_pins_oe_n,
	.irq
);

// [dv/spc_slave_model.sv]
`timescale 1ns/1ps
module spc_slave_model (
	// Serial pins as seen on the wire
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	// Byte to return and byte last received
	input wire logic [7:0] reply,
	output logic [7:0] got
);
	logic [7:0] tx_sh = 8'h00;
	logic [7:0] rx_sh = 8'h00;

	// Selection loads the reply and shows its top bit before any clock.
	always @(negedge ss_n) begin
		tx_sh = reply;
		miso = reply[7];
	end

	// Data is taken on the rising edge; the clock idles low.
	always @(posedge sck) begin
		if (!ss_n) begin
			rx_sh = {rx_sh[6:0], mosi};
		end
	end

	// The next bit goes out on the falling edge.
	always @(negedge sck) begin
		if (!ss_n) begin
			tx_sh = {tx_sh[6:0], 1'h0};
			miso = tx_sh[7];
		end
	end

	// Deselection hands over the byte; the released line stops being valid.
	always @(posedge ss_n) begin
		got = rx_sh;
		miso = ~miso;
	end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import spc_pkg::*;

	// Bus, power and pin stimulus; the pin wire resolves all drivers.
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, stop_mode = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] ext_pins = 8'h80, reply = 8'h00, got;
	logic [7:0] shared_port_pins_out, shared_port_pins_oe_n;
	wire logic miso_line;
	wire logic [7:0] ext_all = {ext_pins[7:5], miso_line, ext_pins[3:0]};
	wire logic [7:0] shared_port_pins_in = (~shared_port_pins_oe_n &
		shared_port_pins_out) | (shared_port_pins_oe_n & ext_all);
	int mismatches = 0;
	int samples_checked = 0;
	typedef struct packed {
		logic [7:0] tx;
		logic [7:0] back;
		logic lsbf;
		logic irqen;
	} spc_row_t;
	spc_row_t rows [4] = '{'{8'hA5, 8'h3C, 1'h0, 1'h0},
		'{8'h01, 8'hFF, 1'h0, 1'h1}, '{8'h80, 8'h00, 1'h1, 1'h0},
		'{8'h5A, 8'hC3, 1'h1, 1'h1}};

	always #4 aclk = ~aclk;

	spc_top dut (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .stop_mode,
		.shared_port_pins_in, .shared_port_pins_out,
		.shared_port_pins_oe_n, .irq
	);
	spc_slave_model slave (
		.sck(shared_port_pins_in[PIN_SCK]),
		.ss_n(shared_port_pins_in[PIN_SS]),
		.mosi(shared_port_pins_in[PIN_MOSI]),
		.miso(miso_line), .reply(reply), .got(got)
	);

	// Verdict and end of run.
	task automatic report_and_stop();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic hang(input string what);
		mismatches++;
		$display("[ERR] %s expected answer seen none", what);
		report_and_stop();
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Bus master: hold each channel until its ready, then wait the answer.
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int n = 0; n < 50 && !bvalid; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end
		if (!bvalid) hang("write response");
		r = bresp;
		bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int n = 0; n < 50 && !rvalid; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end
		if (!rvalid) hang("read data");
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("write response", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask

	task automatic rreg(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(what, {24'h000000, exp}, d);
	endtask

	// Polls status; the read that sees the done flag arms its clearing.
	task automatic wait_done();
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 300; i++) begin
			rd(OFS_STATUS, d, r);
			if (d[7] === 1'h1) return;
		end
		hang("done flag");
	endtask

	// Main sequence: table of bytes, then the power, fault and reset cases.
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] e_rx, e_tx, snap;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rreg("control reset", OFS_CTRL_ONE, 8'h00);
		rreg("status reset", OFS_STATUS, 8'h00);
		wreg(OFS_PORT, 8'h80);
		wreg(OFS_DIR, 8'hE0);
		wreg(OFS_RATE, 8'h03);
		wreg(OFS_IRQ_MASK, 8'h03);
		foreach (rows[i]) begin
			e_rx = {<<{rows[i].back}};
			e_tx = {<<{rows[i].tx}};
			if (!rows[i].lsbf) begin
				e_rx = rows[i].back;
				e_tx = rows[i].tx;
			end
			reply <= rows[i].back;
			wreg(OFS_CTRL_ONE, {rows[i].irqen, 1'h1, 4'h4, 1'h1, rows[i].lsbf});
			wreg(OFS_DATA, rows[i].tx);
			wait_done();
			rreg("received", OFS_DATA, e_rx);
			rreg("status cleared", OFS_STATUS, 8'h00);
			chk("slave byte", {24'h0, e_tx}, {24'h0, got});
			rreg("irq status", OFS_IRQ_STAT, {7'h00, rows[i].irqen});
			chk("irq", {31'h0, rows[i].irqen}, {31'h0, irq});
			wreg(OFS_IRQ_STAT, 8'h01);
			chk("irq cleared", 32'h0, {31'h0, irq});
		end
		rd(8'h24, d, r);
		chk("unmapped read", {30'h0, RESP_SLVERR}, {d[31:2], r});
		wr(8'h24, 8'hFF, r);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
		reply <= 8'h96;
		wreg(OFS_CTRL_ONE, 8'h52);
		wreg(OFS_DATA, 8'h69);
		repeat (40) @(posedge aclk);
		stop_mode <= 1'h1;
		repeat (3) @(posedge aclk);
		snap = shared_port_pins_out;
		repeat (200) @(posedge aclk);
		chk("pins in stop", {24'h0, snap}, {24'h0, shared_port_pins_out});
		rreg("control in stop", OFS_CTRL_ONE, 8'h52);
		rreg("suspect in stop", OFS_STATUS, 8'h08);
		stop_mode <= 1'h0;
		wait_done();
		rd(OFS_DATA, d, r);
		chk("slave after stop", 32'h69, {24'h0, got});
		wreg(OFS_CTRL_ONE, 8'h12);
		wreg(OFS_DATA, 8'h33);
		repeat (200) @(posedge aclk);
		rreg("status disabled", OFS_STATUS, 8'h00);
		wreg(OFS_CTRL_TWO, 8'h5A);
		rreg("control two", OFS_CTRL_TWO, 8'h5A);
		wreg(OFS_CTRL_ONE, 8'h50);
		wreg(OFS_DIR, 8'h60);
		ext_pins[7] <= 1'h0;
		repeat (10) @(posedge aclk);
		rreg("mode fault", OFS_STATUS, 8'h10);
		rreg("irq status fault", OFS_IRQ_STAT, 8'h02);
		chk("irq fault", 32'h1, {31'h0, irq});
		wreg(OFS_IRQ_MASK, 8'h00);
		chk("irq masked", 32'h0, {31'h0, irq});
		wreg(OFS_IRQ_MASK, 8'h03);
		ext_pins[7] <= 1'h1;
		rreg("fault sticky", OFS_STATUS, 8'h10);
		wreg(OFS_CTRL_ONE, 8'h50);
		rreg("fault cleared", OFS_STATUS, 8'h00);
		wreg(OFS_IRQ_STAT, 8'h02);
		chk("irq fault cleared", 32'h0, {31'h0, irq});
		wreg(OFS_DIR, 8'h0F);
		wreg(OFS_PORT, 8'h05);
		// The pin drivers are registered, so let their update settle first.
		@(posedge aclk);
		chk("port drive", 32'h5, {28'h0, shared_port_pins_out[3:0]});
		chk("port enables", 32'h0, {28'h0, shared_port_pins_oe_n[3:0]});
		wreg(OFS_DIR, 8'h00);
		ext_pins[3:0] <= 4'hA;
		repeat (4) @(posedge aclk);
		rd(OFS_PORT, d, r);
		chk("port input", 32'hA, {28'h0, d[3:0]});
		wreg(OFS_PORT, 8'h80);
		wreg(OFS_DIR, 8'hE0);
		wreg(OFS_CTRL_ONE, 8'h12);
		rd(OFS_STATUS, d, r);
		rd(OFS_DATA, d, r);
		wreg(OFS_CTRL_ONE, 8'h52);
		wreg(OFS_DATA, 8'hF0);
		repeat (60) @(posedge aclk);
		aresetn <= 1'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		chk("enables after reset", 32'hFF, {24'h0, shared_port_pins_oe_n});
		rreg("control after reset", OFS_CTRL_ONE, 8'h00);
		rreg("status after reset", OFS_STATUS, 8'h00);
		report_and_stop();
	end
endmodule

// [pkg/spc_pkg.sv]
package spc_pkg;

	// Bus geometry and responses.
	localparam int ADDR_W = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFS_RATE = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_DATA = 8'h10;
	localparam logic [7:0] OFS_DIR = 8'h14;
	localparam logic [7:0] OFS_PORT = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

	// Reset values.
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [2:0] RATE_RST = 3'h0;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [1:0] IRQ_RST = 2'h0;

	// Pin positions within the shared port.
	localparam int PIN_MISO = 4;
	localparam int PIN_MOSI = 5;
	localparam int PIN_SCK = 6;
	localparam int PIN_SS = 7;

	// Interrupt status bit positions.
	localparam int IRQ_DONE = 0;
	localparam int IRQ_MODE_FAULT_FLAG = 1;

	// Last serial clock edge index of a byte (sixteen edges).
	localparam logic [4:0] LAST_EDGE = 5'h0F;

	// Control register one layout.
	typedef struct packed {
		logic transfer_irq_enable;
		logic serial_enable_bit;
		logic rsvd5;
		logic controller_role_bit;
		logic clock_idle_level;
		logic clock_phase_select;
		logic select_out_enable;
		logic lsb_first;
	} spc_ctrl_one_t;

	// Status register layout.
	typedef struct packed {
		logic transfer_done_flag;
		logic write_collision_flag;
		logic rsvd5;
		logic mode_fault_flag;
		logic data_suspect_flag;
		logic [2:0] rsvd;
	} spc_status_t;

	// Shifter states.
	typedef enum {
		SH_IDLE,
		SH_RUN
	} spc_shift_state_t;

	// Reverses bit order for least-significant-bit-first transfers.
	function automatic logic [7:0] spc_reverse(input logic [7:0] d);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = d[7 - i];
		end
		return r;
	endfunction

endpackage

// [verilog/spc_rate_div.sv]
`timescale 1ns/1ps
module spc_rate_div #(
	parameter int SEL_W = 3,
	parameter int CNT_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic en,
	input wire logic [SEL_W-1:0] sel,
	// Half serial period strobe
	output logic tick
);
	import spc_pkg::*;

	// The largest half period is two to the power of the top select value.
	if (CNT_W < (1 << SEL_W)) begin : g_chk
		$error("spc_rate_div: CNT_W too small for SEL_W");
	end

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	wire [CNT_W-1:0] half_m1 = (CNT_W'(1) << sel) - CNT_W'(1);

	// The strobe fires every half serial period while enabled.
	assign tick = en & (cnt_reg == half_m1);
	assign cnt_next = (!en || tick) ? '0 : cnt_reg + CNT_W'(1);

	// Counter restarts whenever the divider is held off.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

endmodule

// [verilog/spc_shifter.sv]
`timescale 1ns/1ps
module spc_shifter (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic step,
	input wire logic start,
	input wire logic [7:0] tx_data,
	input wire logic lsb_first,
	input wire logic idle_level,
	input wire logic phase,
	// Serial data in, already synchronised
	input wire logic miso,
	// Serial outputs
	output logic sck,
	output logic mosi,
	// Status
	output logic busy,
	output logic done,
	output logic [7:0] rx_data
);
	import spc_pkg::*;

	spc_shift_state_t state_reg;
	logic [7:0] sh_reg;
	logic [4:0] edge_reg;
	logic sck_ph_reg;
	logic mosi_reg;
	logic done_reg;
	logic [7:0] rx_reg;

	// Even edges are leading edges; phase picks which edge samples.
	wire sample_now = (edge_reg[0] == phase);
	wire [7:0] sh_in = sample_now ? {sh_reg[6:0], miso} : sh_reg;
	wire last = (edge_reg == LAST_EDGE);
	wire [7:0] tx_ord = lsb_first ? spc_reverse(tx_data) : tx_data;
	wire [7:0] rx_ord = lsb_first ? spc_reverse(sh_in) : sh_in;

	// Outputs from flip-flops; the clock is also XORed with the idle level.
	assign sck = sck_ph_reg ^ idle_level;
	assign mosi = mosi_reg;
	assign busy = (state_reg == SH_RUN);
	assign done = done_reg;
	assign rx_data = rx_reg;

	// One serial edge per step; done pulses after the sixteenth edge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= SH_IDLE;
			sh_reg <= 8'h00;
			edge_reg <= 5'h00;
			sck_ph_reg <= 1'b0;
			mosi_reg <= 1'b0;
			done_reg <= 1'b0;
			rx_reg <= 8'h00;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				SH_IDLE: begin
					if (start) begin
						state_reg <= SH_RUN;
						sh_reg <= tx_ord;
						edge_reg <= 5'h00;
						sck_ph_reg <= 1'b0;
						if (!phase) begin
							mosi_reg <= tx_ord[7];
						end
					end
				end
				SH_RUN: begin
					if (step) begin
						sck_ph_reg <= ~sck_ph_reg;
						sh_reg <= sh_in;
						edge_reg <= edge_reg + 5'h01;
						if (!sample_now) begin
							mosi_reg <= sh_reg[7];
						end
						if (last) begin
							state_reg <= SH_IDLE;
							done_reg <= 1'b1;
							rx_reg <= rx_ord;
							sck_ph_reg <= 1'b0;
						end
					end
				end
				default: begin
					state_reg <= SH_IDLE;
				end
			endcase
		end
	end

endmodule

// [verilog/spc_top.sv]
`timescale 1ns/1ps
module spc_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [spc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [spc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Power mode from the processor
	input wire logic stop_mode,
	// Shared port pins
	input wire logic [7:0] shared_port_pins_in,
	output logic [7:0] shared_port_pins_out,
	output logic [7:0] shared_port_pins_oe_n,
	// Interrupt request
	output logic irq
);
	import spc_pkg::*;

	// Bus state.
	logic aw_have_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic w_have_reg;
	logic [7:0] w_data_reg;
	logic w_lane_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// Register bank.
	spc_ctrl_one_t ctrl_reg;
	logic [7:0] ctrl_two_reg;
	logic [2:0] rate_reg;
	logic [7:0] dir_reg;
	logic [7:0] port_reg;
	logic [1:0] irq_stat_reg;
	logic [1:0] irq_mask_reg;
	logic done_flag_reg;
	logic wcol_flag_reg;
	logic mode_fault_flag_flag_reg;
	logic suspect_flag_reg;
	logic arm_data_reg;
	logic arm_mode_fault_flag_reg;

	// Pin synchroniser and pin drivers.
	logic [7:0] pin_meta_reg;
	logic [7:0] pin_sync_reg;
	logic [7:0] pin_out_reg;
	logic [7:0] pin_oe_n_reg;
	logic [7:0] pin_out_next;
	logic [7:0] pin_oe_n_next;

	// Core signals.
	logic tick;
	logic sh_sck;
	logic sh_mosi;
	logic sh_busy;
	logic sh_done;
	logic [7:0] sh_rx;

	// True for every offset that holds a register.
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFS_CTRL_ONE) || (a == OFS_CTRL_TWO) ||
			(a == OFS_RATE) || (a == OFS_STATUS) || (a == OFS_DATA) ||
			(a == OFS_DIR) || (a == OFS_PORT) || (a == OFS_IRQ_STAT) ||
			(a == OFS_IRQ_MASK);
	endfunction

	// Channel handshakes; one write and one read in flight at most.
	assign awready = ~aw_have_reg & ~bvalid_reg;
	assign wready = ~w_have_reg & ~bvalid_reg;
	assign arready = ~rvalid_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;

	// Write decode, done once both address and data are held.
	wire wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
	wire wr_en = wr_fire & w_lane_reg;
	wire wr_ctrl_one = wr_en & (aw_addr_reg == OFS_CTRL_ONE);
	wire wr_ctrl_two = wr_en & (aw_addr_reg == OFS_CTRL_TWO);
	wire wr_rate = wr_en & (aw_addr_reg == OFS_RATE);
	wire wr_data = wr_en & (aw_addr_reg == OFS_DATA);
	wire wr_dir = wr_en & (aw_addr_reg == OFS_DIR);
	wire wr_port = wr_en & (aw_addr_reg == OFS_PORT);
	wire wr_irq_stat = wr_en & (aw_addr_reg == OFS_IRQ_STAT);
	wire wr_irq_mask = wr_en & (aw_addr_reg == OFS_IRQ_MASK);

	// Read decode, taken in the address handshake cycle.
	wire rd_fire = arvalid & arready;
	wire rd_status = rd_fire & (araddr == OFS_STATUS);
	wire rd_data = rd_fire & (araddr == OFS_DATA);

	// Core gating: the enable bit and stop mode; wait mode gates nothing.
	wire core_en = ctrl_reg.serial_enable_bit & ~stop_mode;
	wire serial_on = ctrl_reg.serial_enable_bit & ctrl_reg.controller_role_bit;
	wire start = wr_data & ~sh_busy & core_en & ctrl_reg.controller_role_bit;

	// Flag set and clear terms.
	wire wcol_set = wr_data & sh_busy;
	wire clr_data = arm_data_reg & (rd_data | wr_data);
	wire clr_mode_fault_flag = arm_mode_fault_flag_reg & wr_ctrl_one;
	wire mode_fault_flag_set = core_en & ctrl_reg.controller_role_bit &
		~dir_reg[PIN_SS] & ~pin_sync_reg[PIN_SS];
	wire suspect_set = stop_mode & sh_busy;
	wire [1:0] irq_set = {mode_fault_flag_set,
		sh_done & ctrl_reg.transfer_irq_enable};
	wire [1:0] irq_clr = wr_irq_stat ? w_data_reg[1:0] : IRQ_RST;

	// Status view assembled from the flags.
	spc_status_t status_view;
	assign status_view = '{transfer_done_flag: done_flag_reg,
		write_collision_flag: wcol_flag_reg, rsvd5: 1'b0,
		mode_fault_flag: mode_fault_flag_flag_reg, data_suspect_flag: suspect_flag_reg,
		rsvd: 3'h0};

	// Read data selection.
	wire [7:0] rd_byte =
		(araddr == OFS_CTRL_ONE) ? ctrl_reg :
		(araddr == OFS_CTRL_TWO) ? ctrl_two_reg :
		(araddr == OFS_RATE) ? {5'h00, rate_reg} :
		(araddr == OFS_STATUS) ? status_view :
		(araddr == OFS_DATA) ? sh_rx :
		(araddr == OFS_DIR) ? dir_reg :
		(araddr == OFS_PORT) ? pin_sync_reg :
		(araddr == OFS_IRQ_STAT) ? {6'h00, irq_stat_reg} :
		(araddr == OFS_IRQ_MASK) ? {6'h00, irq_mask_reg} : 8'h00;

	// Shared request: sticky status gated by mask; also wakes from wait.
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// Write address and data capture, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_have_reg <= 1'b0;
			w_data_reg <= 8'h00;
			w_lane_reg <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= awaddr;
			end else if (wr_fire) begin
				aw_have_reg <= 1'b0;
			end
			if (wvalid && wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= wdata[7:0];
				w_lane_reg <= wstrb[0];
			end else if (wr_fire) begin
				w_have_reg <= 1'b0;
			end
		end
	end

	// Write response and read data; unmapped offsets answer SLVERR.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else begin
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid_reg <= 1'b0;
			end
			if (rd_fire) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= {24'h00_0000, rd_byte};
				rresp_reg <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// Configuration registers on the bus clock, kept through stop.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CTRL_ONE_RST;
			ctrl_two_reg <= CTRL_TWO_RST;
			rate_reg <= RATE_RST;
			dir_reg <= DIR_RST;
			port_reg <= PORT_RST;
			irq_mask_reg <= IRQ_RST;
		end else begin
			if (wr_ctrl_one) ctrl_reg <= w_data_reg;
			if (wr_ctrl_two) ctrl_two_reg <= w_data_reg;
			if (wr_rate) rate_reg <= w_data_reg[2:0];
			if (wr_dir) dir_reg <= w_data_reg;
			if (wr_port) port_reg <= w_data_reg;
			if (wr_irq_mask) irq_mask_reg <= w_data_reg[1:0];
		end
	end

	// Status flags; a set in the clearing cycle wins over the clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_flag_reg <= 1'b0;
			wcol_flag_reg <= 1'b0;
			mode_fault_flag_flag_reg <= 1'b0;
			suspect_flag_reg <= 1'b0;
			irq_stat_reg <= IRQ_RST;
		end else begin
			done_flag_reg <= sh_done | (done_flag_reg & ~clr_data);
			wcol_flag_reg <= wcol_set | (wcol_flag_reg & ~clr_data);
			mode_fault_flag_flag_reg <= mode_fault_flag_set | (mode_fault_flag_flag_reg & ~clr_mode_fault_flag);
			suspect_flag_reg <= suspect_set | (suspect_flag_reg & ~clr_data);
			irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);
		end
	end

	// First steps of the clearing sequences: a status read with flags set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arm_data_reg <= 1'b0;
			arm_mode_fault_flag_reg <= 1'b0;
		end else begin
			if (rd_status && (done_flag_reg || wcol_flag_reg)) begin
				arm_data_reg <= 1'b1;
			end else if (clr_data) begin
				arm_data_reg <= 1'b0;
			end
			if (rd_status && mode_fault_flag_flag_reg) begin
				arm_mode_fault_flag_reg <= 1'b1;
			end else if (clr_mode_fault_flag) begin
				arm_mode_fault_flag_reg <= 1'b0;
			end
		end
	end

	// Two-flop synchroniser on all port inputs.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_reg <= 8'h00;
			pin_sync_reg <= 8'h00;
		end else begin
			pin_meta_reg <= shared_port_pins_in;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// Per-pin function: serial role on the upper four pins, else port I/O.
	for (genvar i = 0; i < 8; i++) begin : g_pin
		if (i == PIN_MOSI) begin : g_mosi
			assign pin_out_next[i] = serial_on ? sh_mosi : port_reg[i];
			assign pin_oe_n_next[i] = ~dir_reg[i];
		end else if (i == PIN_SCK) begin : g_sck
			assign pin_out_next[i] = serial_on ? sh_sck : port_reg[i];
			assign pin_oe_n_next[i] = ~dir_reg[i];
		end else if (i == PIN_SS) begin : g_ss
			assign pin_out_next[i] =
				(serial_on & ctrl_reg.select_out_enable) ? ~sh_busy :
				port_reg[i];
			assign pin_oe_n_next[i] = ~dir_reg[i];
		end else if (i == PIN_MISO) begin : g_miso
			assign pin_out_next[i] = port_reg[i];
			assign pin_oe_n_next[i] = ~(dir_reg[i] & ~serial_on);
		end else begin : g_gpio
			assign pin_out_next[i] = port_reg[i];
			assign pin_oe_n_next[i] = ~dir_reg[i];
		end
	end

	// Registered pin drivers; all pins released during reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out_reg <= 8'h00;
			pin_oe_n_reg <= 8'hFF;
		end else begin
			pin_out_reg <= pin_out_next;
			pin_oe_n_reg <= pin_oe_n_next;
		end
	end

	assign shared_port_pins_out = pin_out_reg;
	assign shared_port_pins_oe_n = pin_oe_n_reg;

	// Rate divider runs only for an enabled core with a byte in flight.
	spc_rate_div #(
		.SEL_W(3),
		.CNT_W(8)
	) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.en(core_en & sh_busy),
		.sel(rate_reg),
		.tick(tick)
	);

	// Shift engine; freezes in place while the core is held off.
	spc_shifter u_shift (
		.aclk(aclk),
		.aresetn(aresetn),
		.step(tick),
		.start(start),
		.tx_data(w_data_reg),
		.lsb_first(ctrl_reg.lsb_first),
		.idle_level(ctrl_reg.clock_idle_level),
		.phase(ctrl_reg.clock_phase_select),
		.miso(pin_sync_reg[PIN_MISO]),
		.sck(sh_sck),
		.mosi(sh_mosi),
		.busy(sh_busy),
		.done(sh_done),
		.rx_data(sh_rx)
	);

endmodule
